// [hdl/sbsc_map.vh]
// constants of the sram burst and sleep control block
// assumes inclusion by bare name from the design files
`ifndef SBSC_MAP_VH
`define SBSC_MAP_VH

// memory array and pin widths
`define SBSC_ADDR_W 8
`define SBSC_DATA_W 16
`define SBSC_DEPTH 256
`define SBSC_BURST_W 2
`define SBSC_CNT_W 16

// sleep entry and wake-up, in clock cycles
`define SBSC_SLEEP_ENTRY_CYC 2'h2
`define SBSC_SLEEP_EXIT_CYC 2'h2

// avalon register word addresses
`define SBSC_REG_CTRL 3'h0
`define SBSC_REG_STATUS 3'h1
`define SBSC_REG_ADDR 3'h2
`define SBSC_REG_COUNT 3'h3

// control register fields and reset
`define SBSC_CTRL_ENABLE 0
`define SBSC_CTRL_CLEAR 1
`define SBSC_CTRL_EN_RST 1'h1

// mode pin vector: index and default level
`define SBSC_MODE_SLEEP 0
`define SBSC_MODE_ORDER 1
`define SBSC_MODE_FT 2
`define SBSC_MODE_DRIVE 3
`define SBSC_MODE_N 4
`define SBSC_MODE_RST 4'hc

// status register fields
`define SBSC_ST_STATE 0
`define SBSC_ST_ORDER 2
`define SBSC_ST_FT 3
`define SBSC_ST_DRIVE 4
`define SBSC_ST_SLEEPREQ 5
`define SBSC_ST_BCNT 6
`define SBSC_ST_PEND 8

`endif

// [hdl/sbsc_bgen.v]
// two-bit burst address generator, linear or interleaved order
// assumes load and step are never high together
`timescale 1ns/10ps
`include "sbsc_map.vh"

module sbsc_bgen (
    // clock and reset
    input wire clk_i,
    input wire nrst_i,
    // control
    input wire load_i,
    input wire step_i,
    input wire order_i,
    input wire [`SBSC_BURST_W-1:0] start_i,
    // generated address bits and burst count
    output wire [`SBSC_BURST_W-1:0] addr_o,
    output wire [`SBSC_BURST_W-1:0] count_o
);

reg [`SBSC_BURST_W-1:0] start_reg;
reg [`SBSC_BURST_W-1:0] cnt_reg;
wire [`SBSC_BURST_W-1:0] step_cnt;

// natural wrap of the two-bit count returns to the start after four
assign step_cnt = cnt_reg + 2'h1;
assign addr_o = order_i ? (start_reg ^ step_cnt) : (start_reg + step_cnt);
assign count_o = cnt_reg;

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        start_reg <= 2'h0;
        cnt_reg <= 2'h0;
    end else if (load_i) begin
        start_reg <= start_i;
        cnt_reg <= 2'h0;
    end else if (step_i) begin
        cnt_reg <= step_cnt;
    end
end

endmodule // sbsc_bgen

// [hdl/sbsc_top.v]
// sram burst sequencing, mode pins and sleep control with avalon registers
// assumes host pins are synchronous to clk_i; mode and sleep pins are not
`timescale 1ns/10ps
`include "sbsc_map.vh"

// Function
// - back-to-back reads, writes and read-to-write run with no idle cycles
// - advance high steps the burst counter and uses its address
// - advance low loads the external address as burst start
// - counter returns to its start after four accesses
// - order select low: low bits count up modulo four
// - order select high: low bits are start xor step count
// - flow-through select low gives flow-through reads, high pipelined
// - unconnected mode pins default to pipelined, high drive select, awake
// - sleep state entered two cycles after sleep request rises
// - sleep keeps memory contents and internal state
// - normal operation resumes two cycles after sleep request falls
// - asleep: deselected, inputs ignored, outputs released
// - sleep request is asynchronous and active high
// - burst generator is a two-bit counter
// - every burst-continue cycle with clock gate low and not asleep increments the counter
// - clock gate high is a wait state freezing the access pipeline, burst counter, memory and outputs; sleep sequencing keeps running
module sbsc_top (
    // clock and reset
    input wire clk_i,
    input wire nrst_i,
    // avalon-mm register slave
    input wire [2:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    output wire [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    // synchronous sram pins
    input wire [`SBSC_ADDR_W-1:0] sram_addr_i,
    input wire burst_advance_load_i,
    input wire write_n_i,
    input wire chip_enable_n_i,
    input wire clock_gate_n_i,
    input wire [`SBSC_DATA_W-1:0] data_i,
    output wire [`SBSC_DATA_W-1:0] data_o,
    output wire data_oe_o,
    // asynchronous mode pins
    input wire burst_order_select_i,
    input wire flow_through_select_i,
    input wire drive_strength_select_i,
    input wire sleep_request_i,
    // status pins
    output wire sleep_o,
    output wire drive_strength_o
);

localparam [1:0] ST_ACTIVE = 2'b00;
localparam [1:0] ST_ENTER = 2'b01;
localparam [1:0] ST_SLEEP = 2'b10;
localparam [1:0] ST_WAKE = 2'b11;
localparam [`SBSC_MODE_N-1:0] MODE_RST = `SBSC_MODE_RST;

// counting phase reaches its limit on this edge
function cnt_done;
    input [1:0] c;
    input [1:0] lim;
    begin
        cnt_done = ((c + 2'h1) == lim);
    end
endfunction

// mode pin synchronisers
wire [`SBSC_MODE_N-1:0] mode_raw;
wire [`SBSC_MODE_N-1:0] mode;

assign mode_raw = {drive_strength_select_i, flow_through_select_i,
                   burst_order_select_i, sleep_request_i};

genvar g;
generate
    for (g = 0; g < `SBSC_MODE_N; g = g + 1) begin : g_sync
        reg [2:0] sh_reg;
        reg lvl_reg;
        always @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                sh_reg <= {3{MODE_RST[g]}};
                lvl_reg <= MODE_RST[g];
            end else begin
                sh_reg <= {sh_reg[1:0], mode_raw[g]};
                // accepted only once second and third stage agree
                if (sh_reg[1] == sh_reg[2]) begin
                    lvl_reg <= sh_reg[2];
                end
            end
        end
        assign mode[g] = lvl_reg;
    end
endgenerate

wire sleep_lvl;
wire order_sel;
wire ft_sel;

assign sleep_lvl = mode[`SBSC_MODE_SLEEP];
assign order_sel = mode[`SBSC_MODE_ORDER];
assign ft_sel = mode[`SBSC_MODE_FT];

// sleep sequencing
reg [1:0] state_reg;
reg [1:0] state_next;
reg [1:0] scnt_reg;
reg [1:0] scnt_next;
reg sleep_reg;

always @* begin
    state_next = state_reg;
    scnt_next = scnt_reg;
    case (state_reg)
        ST_ACTIVE: begin
            if (sleep_lvl) begin
                state_next = ST_ENTER;
                scnt_next = 2'h1;
            end
        end
        ST_ENTER: begin
            if (!sleep_lvl) begin
                state_next = ST_ACTIVE;
            end else if (cnt_done(scnt_reg, `SBSC_SLEEP_ENTRY_CYC)) begin
                state_next = ST_SLEEP;
            end else begin
                scnt_next = scnt_reg + 2'h1;
            end
        end
        ST_SLEEP: begin
            if (!sleep_lvl) begin
                state_next = ST_WAKE;
                scnt_next = 2'h1;
            end
        end
        ST_WAKE: begin
            if (sleep_lvl) begin
                state_next = ST_SLEEP;
            end else if (cnt_done(scnt_reg, `SBSC_SLEEP_EXIT_CYC)) begin
                state_next = ST_ACTIVE;
            end else begin
                scnt_next = scnt_reg + 2'h1;
            end
        end
        default: begin
            state_next = ST_ACTIVE;
            scnt_next = 2'h0;
        end
    endcase
end

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        state_reg <= ST_ACTIVE;
        scnt_reg <= 2'h0;
        sleep_reg <= 1'h0;
    end else begin
        state_reg <= state_next;
        scnt_reg <= scnt_next;
        sleep_reg <= (state_next == ST_SLEEP);
    end
end

wire asleep;
wire recovering;

assign asleep = (state_reg == ST_SLEEP);
assign recovering = (state_reg == ST_WAKE);

// command stage
reg ctrl_en_reg;
reg last_valid_reg;
reg last_write_reg;
reg [`SBSC_ADDR_W-1:0] base_reg;
reg s1_valid_reg;
reg s1_write_reg;
reg [`SBSC_ADDR_W-1:0] s1_addr_reg;
reg s2_valid_reg;
reg s2_write_reg;
reg [`SBSC_ADDR_W-1:0] s2_addr_reg;
reg [`SBSC_ADDR_W-1:0] last_addr_reg;
reg [`SBSC_CNT_W-1:0] count_reg;
reg clear_req;

wire go;
wire [`SBSC_BURST_W-1:0] burst_low;
wire [`SBSC_BURST_W-1:0] burst_cnt;
reg c_valid;
reg c_write;
reg [`SBSC_ADDR_W-1:0] c_addr;

// asleep or clock gate high: nothing moves, so state survives
assign go = !clock_gate_n_i && !asleep;

always @* begin
    c_valid = 1'h0;
    c_write = 1'h0;
    c_addr = sram_addr_i;
    if (burst_advance_load_i) begin
        // continue keeps the type of the burst, a deselect stays one
        c_valid = last_valid_reg;
        c_write = last_write_reg;
        c_addr = {base_reg[`SBSC_ADDR_W-1:`SBSC_BURST_W], burst_low};
    end else begin
        c_valid = ctrl_en_reg && !chip_enable_n_i;
        c_write = !write_n_i;
    end
    // writes in recovery could be lost, so they become deselects
    if (recovering && c_write) begin
        c_valid = 1'h0;
    end
end

sbsc_bgen u_bgen (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(go && !burst_advance_load_i),
    .step_i(go && burst_advance_load_i),
    .order_i(order_sel),
    .start_i(sram_addr_i[`SBSC_BURST_W-1:0]),
    .addr_o(burst_low),
    .count_o(burst_cnt)
);

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        last_valid_reg <= 1'h0;
        last_write_reg <= 1'h0;
        base_reg <= {`SBSC_ADDR_W{1'b0}};
        s1_valid_reg <= 1'h0;
        s1_write_reg <= 1'h0;
        s1_addr_reg <= {`SBSC_ADDR_W{1'b0}};
        s2_valid_reg <= 1'h0;
        s2_write_reg <= 1'h0;
        s2_addr_reg <= {`SBSC_ADDR_W{1'b0}};
        last_addr_reg <= {`SBSC_ADDR_W{1'b0}};
    end else if (go) begin
        last_valid_reg <= c_valid;
        last_write_reg <= c_write;
        if (!burst_advance_load_i) begin
            base_reg <= sram_addr_i;
        end
        // a new command every cycle, with no turnaround slot
        s1_valid_reg <= c_valid;
        s1_write_reg <= c_write;
        s1_addr_reg <= c_addr;
        s2_valid_reg <= s1_valid_reg;
        s2_write_reg <= s1_write_reg;
        s2_addr_reg <= s1_addr_reg;
        if (c_valid) begin
            last_addr_reg <= c_addr;
        end
    end
end

// data stage: pipelined uses the second stage, flow-through the first
reg [`SBSC_DATA_W-1:0] mem [0:`SBSC_DEPTH-1];
reg [`SBSC_DATA_W-1:0] dout_reg;
reg oe_reg;
wire d_valid;
wire d_write;
wire [`SBSC_ADDR_W-1:0] d_addr;

assign d_valid = ft_sel ? s2_valid_reg : s1_valid_reg;
assign d_write = ft_sel ? s2_write_reg : s1_write_reg;
assign d_addr = ft_sel ? s2_addr_reg : s1_addr_reg;

always @(posedge clk_i) begin
    if (go && d_valid && d_write) begin
        mem[d_addr] <= data_i;
    end
end

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        dout_reg <= {`SBSC_DATA_W{1'b0}};
        oe_reg <= 1'h0;
    end else if (asleep) begin
        oe_reg <= 1'h0;
    end else if (go) begin
        if (d_valid && !d_write) begin
            dout_reg <= mem[d_addr];
            oe_reg <= 1'h1;
        end else begin
            oe_reg <= 1'h0;
        end
    end
end

// access counter; a clear in the same cycle as an access keeps that access
always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        count_reg <= {`SBSC_CNT_W{1'b0}};
    end else if (clear_req) begin
        count_reg <= {{(`SBSC_CNT_W-1){1'b0}}, go && c_valid};
    end else if (go && c_valid) begin
        count_reg <= count_reg + {{(`SBSC_CNT_W-1){1'b0}}, 1'b1};
    end
end

// avalon slave: one wait cycle on every access
reg wait_reg;
reg [31:0] rdata_reg;
reg [31:0] rd_val;
wire req;
wire take;

assign req = avs_read_i || avs_write_i;
assign take = req && !wait_reg;

always @* begin
    clear_req = take && avs_write_i && (avs_address_i == `SBSC_REG_CTRL) &&
                avs_writedata_i[`SBSC_CTRL_CLEAR];
end

always @* begin
    rd_val = 32'h0;
    case (avs_address_i)
        `SBSC_REG_CTRL: begin
            rd_val[`SBSC_CTRL_ENABLE] = ctrl_en_reg;
        end
        `SBSC_REG_STATUS: begin
            rd_val[`SBSC_ST_STATE+1:`SBSC_ST_STATE] = state_reg;
            rd_val[`SBSC_ST_ORDER] = order_sel;
            rd_val[`SBSC_ST_FT] = ft_sel;
            rd_val[`SBSC_ST_DRIVE] = mode[`SBSC_MODE_DRIVE];
            rd_val[`SBSC_ST_SLEEPREQ] = sleep_lvl;
            rd_val[`SBSC_ST_BCNT+1:`SBSC_ST_BCNT] = burst_cnt;
            rd_val[`SBSC_ST_PEND] = s1_valid_reg || s2_valid_reg;
        end
        `SBSC_REG_ADDR: begin
            rd_val[`SBSC_ADDR_W-1:0] = last_addr_reg;
        end
        `SBSC_REG_COUNT: begin
            rd_val[`SBSC_CNT_W-1:0] = count_reg;
        end
        default: begin
            rd_val = 32'h0;
        end
    endcase
end

always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        wait_reg <= 1'h1;
        rdata_reg <= 32'h0;
        ctrl_en_reg <= `SBSC_CTRL_EN_RST;
    end else begin
        wait_reg <= !(req && wait_reg);
        if (avs_read_i && wait_reg) begin
            rdata_reg <= rd_val;
        end
        if (take && avs_write_i && (avs_address_i == `SBSC_REG_CTRL)) begin
            ctrl_en_reg <= avs_writedata_i[`SBSC_CTRL_ENABLE];
        end
    end
end

assign avs_readdata_o = rdata_reg;
assign avs_waitrequest_o = wait_reg;
assign data_o = dout_reg;
assign data_oe_o = oe_reg;
assign sleep_o = sleep_reg;
assign drive_strength_o = mode[`SBSC_MODE_DRIVE];

endmodule // sbsc_top

// [verification/sbsc_host.sv]
// host controller model driving the sram pins of the block
// assumes one bench process calls its tasks; pins change at rising edges
`timescale 1ns/10ps
module sbsc_host (
    // clock
    input wire clk_i,
    // synchronous pins
    output reg [7:0] addr_o,
    output reg adv_o,
    output reg we_n_o,
    output reg ce_n_o,
    output reg gate_n_o,
    output wire [15:0] wdata_o,
    // mode pins
    output reg order_o,
    output reg ft_o,
    output reg drive_o,
    output reg sleep_req_o
);
    reg [15:0] wd = 16'h0000;
    reg [15:0] d1 = 16'h0000;
    reg [15:0] d2 = 16'h0000;
    reg prev = 1'b0;
    reg [3:0] rec = 4'h0;
    // write data lags the command by the data stage of the mode
    assign wdata_o = ft_o ? d2 : d1;
    initial begin
        addr_o = 8'h00;
        {adv_o, we_n_o, ce_n_o, gate_n_o} = 4'h6;
        {order_o, ft_o, drive_o, sleep_req_o} = 4'h6;
    end
    always @(posedge clk_i) begin
        d1 <= wd;
        d2 <= d1;
        prev <= sleep_req_o;
        rec <= (prev && !sleep_req_o) ? 4'h8 : (rec != 4'h0 ? rec - 4'h1 : 4'h0);
    end
    // one command a cycle, any mix back to back
    task op(input logic ld, input logic wr, input logic [7:0] a, input logic [15:0] d);
        begin
            @(posedge clk_i);
            addr_o <= a;
            adv_o <= !ld;
            we_n_o <= !(wr && rec == 4'h0 && prev == sleep_req_o);
            ce_n_o <= 1'b0;
            gate_n_o <= 1'b0;
            wd <= wr ? d : ~wd;
        end
    endtask
    task idle(input int n);
        begin
            repeat (n) begin
                @(posedge clk_i);
                {adv_o, we_n_o, ce_n_o, gate_n_o} <= 4'h6;
                wd <= ~wd;
            end
        end
    endtask
    // limitation: write data keeps moving, so only reads may be held
    task hold(input int n);
        begin
            repeat (n) begin
                @(posedge clk_i);
                gate_n_o <= 1'b1;
                addr_o <= ~addr_o;
            end
        end
    endtask
    task mode(input logic o, input logic f, input logic s);
        begin
            @(posedge clk_i);
            {order_o, ft_o, drive_o} <= {o, f, s};
            idle(8);
        end
    endtask
    // quiet bus first so nothing is in flight when sleep starts
    task sleep_on;
        begin
            idle(4);
            sleep_req_o <= 1'b1;
        end
    endtask
    task sleep_off;
        begin
            @(posedge clk_i);
            sleep_req_o <= 1'b0;
        end
    endtask
endmodule // sbsc_host

// [verification/sbsc_top_asserts.sv]
// port checks of the sram burst and sleep control block
// assumes mode pins settle for eight cycles before accesses
`timescale 1ns/10ps
module sbsc_chk (
    // clock and reset
    input wire clk_i,
    input wire nrst_i,
    // sram pins
    input wire burst_advance_load_i,
    input wire write_n_i,
    input wire chip_enable_n_i,
    input wire clock_gate_n_i,
    input wire [15:0] data_o,
    input wire data_oe_o,
    // mode and status pins
    input wire flow_through_select_i,
    input wire drive_strength_select_i,
    input wire sleep_request_i,
    input wire sleep_o,
    input wire drive_strength_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    // load cycle that the device has to take
    wire go = !clock_gate_n_i && !burst_advance_load_i && !chip_enable_n_i && !sleep_o
        && !sleep_request_i;
    a_pipe_read: assert property (
        go && write_n_i && flow_through_select_i ##1 !clock_gate_n_i [*2] |-> ##1 data_oe_o)
        else $error("pipelined read gave no data");
    a_flow_read: assert property (
        go && write_n_i && !flow_through_select_i ##1 !clock_gate_n_i |-> ##1 data_oe_o)
        else $error("flow read gave no data");
    a_write_quiet: assert property (
        go && !write_n_i && flow_through_select_i ##1 !clock_gate_n_i [*2] |-> ##1 !data_oe_o)
        else $error("driver on in write stage");
    a_gate_hold: assert property (
        clock_gate_n_i && !sleep_o && !sleep_request_i |=> $stable(data_oe_o) && $stable(data_o))
        else $error("outputs moved in wait state");
    a_sleep_entry: assert property (sleep_request_i [*8] |-> sleep_o)
        else $error("sleep not entered");
    a_sleep_min: assert property ($rose(sleep_o) |-> $past(sleep_request_i, 2))
        else $error("sleep entered early");
    a_wake_exit: assert property (!sleep_request_i [*8] |-> !sleep_o)
        else $error("sleep not left");
    a_wake_min: assert property ($fell(sleep_o) |-> !$past(sleep_request_i, 2))
        else $error("sleep left early");
    a_sleep_hiz: assert property (sleep_o |-> !data_oe_o)
        else $error("driver on in sleep");
    a_drive_follow: assert property (drive_strength_select_i [*6] |-> drive_strength_o)
        else $error("drive select not followed");
    c_read: cover property (go && write_n_i ##3 data_oe_o);
    c_sleep: cover property ($rose(sleep_o));
    c_gate: cover property (clock_gate_n_i && data_oe_o);
endmodule // sbsc_chk
bind sbsc_top sbsc_chk u_sbsc_chk (.clk_i, .nrst_i, .burst_advance_load_i, .write_n_i,
    .chip_enable_n_i, .clock_gate_n_i, .data_o, .data_oe_o, .flow_through_select_i,
    .drive_strength_select_i, .sleep_request_i, .sleep_o, .drive_strength_o);

// [verification/sbsc_tb.sv]
// self-checking bench of the sram burst and sleep control block
// assumes the host model owns the sram pins and the bench the register bus
`timescale 1ns/10ps
module tb;
    reg clk_i;
    reg nrst_i;
    reg [2:0] avs_address_i;
    reg avs_read_i;
    reg avs_write_i;
    reg [31:0] avs_writedata_i;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o;
    wire [7:0] sram_addr_i;
    wire burst_advance_load_i;
    wire write_n_i;
    wire chip_enable_n_i;
    wire clock_gate_n_i;
    wire [15:0] data_i;
    wire [15:0] data_o;
    wire data_oe_o;
    wire burst_order_select_i;
    wire flow_through_select_i;
    wire drive_strength_select_i;
    wire sleep_request_i;
    wire sleep_o;
    wire drive_strength_o;
    int err_total = 0;
    int checks_done = 0;
    reg g1 = 1'b1;
    logic [15:0] seen[$];
    logic [31:0] q;
    always #20 clk_i = ~clk_i;
    sbsc_top u_sbsc_top (.clk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .sram_addr_i,
        .burst_advance_load_i, .write_n_i, .chip_enable_n_i, .clock_gate_n_i, .data_i,
        .data_o, .data_oe_o, .burst_order_select_i, .flow_through_select_i,
        .drive_strength_select_i, .sleep_request_i, .sleep_o, .drive_strength_o);
    sbsc_host u_sbsc_host (.clk_i(clk_i), .addr_o(sram_addr_i), .adv_o(burst_advance_load_i),
        .we_n_o(write_n_i), .ce_n_o(chip_enable_n_i), .gate_n_o(clock_gate_n_i),
        .wdata_o(data_i), .order_o(burst_order_select_i), .ft_o(flow_through_select_i),
        .drive_o(drive_strength_select_i), .sleep_req_o(sleep_request_i));
    // frozen cycles repeat the last word, so only fresh outputs are logged
    always @(posedge clk_i) begin
        g1 <= clock_gate_n_i;
        if (data_oe_o === 1'b1 && g1 === 1'b0)
            seen.push_back(data_o);
    end
    function automatic logic [15:0] pat(input logic [7:0] a);
        pat = {8'h5a, a};
    endfunction
    task tally_and_finish;
        begin
            if (err_total == 0 && checks_done > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task avs(input logic wr, input logic [2:0] a, input logic [31:0] d);
        int n;
        begin
            @(posedge clk_i);
            avs_address_i <= a;
            avs_read_i <= !wr;
            avs_write_i <= wr;
            avs_writedata_i <= d;
            n = 0;
            @(posedge clk_i);
            while (avs_waitrequest_o !== 1'b0) begin
                n = n + 1;
                if (n > 40) begin
                    err_total = err_total + 1;
                    tally_and_finish;
                end
                @(posedge clk_i);
            end
            q = avs_readdata_o;
            avs_read_i <= 1'b0;
            avs_write_i <= 1'b0;
        end
    endtask
    task t_reset;
        begin
            check(32'({sleep_o, data_oe_o, drive_strength_o}), 32'h1);
            avs(1'b0, 3'h1, 32'h0);
            check(q & 32'h3f, 32'h18);
            avs(1'b1, 3'h6, 32'hffffffff);
            avs(1'b0, 3'h6, 32'h0);
            check(q, 32'h0);
        end
    endtask
    task t_burst;
        int i;
        int k;
        logic [1:0] lo;
        logic [7:0] s;
        begin
            for (i = 0; i < 8; i++)
                u_sbsc_host.op(1'b1, 1'b1, 8'h20 + 8'(i), pat(8'h20 + 8'(i)));
            u_sbsc_host.op(1'b1, 1'b0, 8'h27, 16'h0);
            // one idle beyond the logging edge of the last word
            u_sbsc_host.idle(5);
            check(32'(seen.size()), 32'h1);
            check(32'(seen[0]), 32'(pat(8'h27)));
            for (i = 0; i < 2; i++) begin
                s = 8'h21 + 8'(i);
                u_sbsc_host.mode(i[0], 1'b1, 1'b1);
                seen.delete();
                u_sbsc_host.op(1'b1, 1'b0, s, 16'h0);
                repeat (4) u_sbsc_host.op(1'b0, 1'b0, 8'h00, 16'h0);
                u_sbsc_host.idle(5);
                check(32'(seen.size()), 32'h5);
                for (k = 0; k < 5; k++) begin
                    lo = i[0] ? (s[1:0] ^ 2'(k)) : (s[1:0] + 2'(k));
                    check(32'(seen[k]), 32'(pat({s[7:2], lo})));
                end
            end
        end
    endtask
    task t_gate;
        begin
            u_sbsc_host.mode(1'b0, 1'b1, 1'b1);
            seen.delete();
            u_sbsc_host.op(1'b1, 1'b0, 8'h24, 16'h0);
            u_sbsc_host.hold(3);
            u_sbsc_host.op(1'b0, 1'b0, 8'h00, 16'h0);
            u_sbsc_host.idle(5);
            check(32'(seen.size()), 32'h2);
            check(32'(seen[1]), 32'(pat(8'h25)));
        end
    endtask
    task t_flow;
        begin
            u_sbsc_host.mode(1'b0, 1'b0, 1'b0);
            avs(1'b1, 3'h0, 32'h3);
            seen.delete();
            u_sbsc_host.op(1'b1, 1'b1, 8'h26, 16'hc3c3);
            u_sbsc_host.op(1'b1, 1'b0, 8'h25, 16'h0);
            u_sbsc_host.op(1'b1, 1'b0, 8'h26, 16'h0);
            u_sbsc_host.idle(4);
            check(32'(seen[0]), 32'(pat(8'h25)));
            check(32'(seen[1]), 32'hc3c3);
            check(32'(drive_strength_o), 32'h0);
            avs(1'b0, 3'h3, 32'h0);
            check(q & 32'hffff, 32'h3);
            avs(1'b0, 3'h1, 32'h0);
            check(q & 32'h18, 32'h0);
            u_sbsc_host.mode(1'b0, 1'b1, 1'b1);
        end
    endtask
    task t_sleep;
        begin
            u_sbsc_host.op(1'b1, 1'b1, 8'h30, 16'h1234);
            u_sbsc_host.sleep_on;
            u_sbsc_host.idle(10);
            check(32'(sleep_o), 32'h1);
            avs(1'b0, 3'h1, 32'h0);
            check(q & 32'h3, 32'h2);
            seen.delete();
            u_sbsc_host.op(1'b1, 1'b1, 8'h30, 16'hdead);
            u_sbsc_host.op(1'b1, 1'b0, 8'h30, 16'h0);
            u_sbsc_host.idle(4);
            check(32'(seen.size()), 32'h0);
            u_sbsc_host.sleep_off;
            u_sbsc_host.op(1'b1, 1'b1, 8'h30, 16'hbeef);
            u_sbsc_host.idle(12);
            check(32'(sleep_o), 32'h0);
            u_sbsc_host.op(1'b1, 1'b0, 8'h30, 16'h0);
            u_sbsc_host.idle(5);
            check(32'(seen[0]), 32'h1234);
        end
    endtask
    initial begin
        clk_i = 1'b0;
        nrst_i = 1'b0;
        avs_address_i = 3'h0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0;
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        t_reset;
        t_burst;
        t_gate;
        t_flow;
        t_sleep;
        tally_and_finish;
    end
endmodule // tb
